// File: rtl/power_down_mode_control.sv
// Power-down mode controller with an AXI4-Lite register slave.
// Assumes interrupt lines and the multiplier strap are asynchronous pins; aresetn is the device reset.
//
// Notes on behaviour
// - Bits 15 to 10 of control_status select the power-down mode and wake method.
// - Light sleep takes effect eight cycles after the write of the field.
// - A non-enabled wake resumes at the sleep point without a service routine.
// - An enabled wake runs the service routine first, then resumes.
// - The service routine runs only when both interrupt enable bits are set.
// - Clock-stop and PLL-stop sleeps end only by device reset.
// - Code 001001 is light sleep woken only by an enabled interrupt.
// - Code 010001 is light sleep woken by any interrupt.
// - Light sleep gates the CPU clock but keeps interrupt logic clocked.
// - DMA keeps running during light sleep.
// - Code 011010 halts the PLL output and the whole internal clock tree.
// - Deep sleeps keep all state and freeze functional outputs.
// - Code 011100 stops the PLL input clock.
// - After reset the CPU waits for PLL lock before running.
// - The lock wait allows the typical lock time plus 150 percent.
// - Asynchronous peripherals may still toggle in deep sleep, unguaranteed.
// - Times-one selection bypasses the PLL; the reference is the CPU clock.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module power_down_mode_control
#(
   parameter int NINT = 12,
   parameter int REF_DIV = pdm_pkg::REF_DIV_DEF,
   parameter int LOCK_CYCLES = pdm_pkg::LOCK_CYCLES_DEF
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [pdm_pkg::AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [pdm_pkg::AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [NINT-1:0] int_request,
   input wire logic clock_mult_select,
   output logic cpu_core_enable,
   output logic int_logic_enable,
   output logic dma_enable,
   output logic pll_out_enable,
   output logic pll_in_enable,
   output logic io_freeze,
   output logic sleep_active,
   output logic wake_isr,
   output logic wake_resume,
   output logic cpu_clock_out,
   output logic half_clock_out
);
   import pdm_pkg::*;

   function automatic logic [1:0] reg_index(input logic [AXI_AW-1:0] addr);
      case (addr)
         CTRL_STATUS_OFS: reg_index = IDX_CTRL;
         INT_ENABLE_OFS: reg_index = IDX_IE;
         PD_STATUS_OFS: reg_index = IDX_STAT;
         default: reg_index = IDX_NONE;
      endcase
   endfunction : reg_index

   function automatic logic is_pd_code(input logic [5:0] code);
      is_pd_code = (code == PD_LIGHT_EN) || (code == PD_LIGHT_ANY) ||
                   (code == PD_CLK_STOP) || (code == PD_PLL_STOP);
   endfunction : is_pd_code

   // Pin synchronisers: a change counts once the second and third stages agree.
   localparam int NPIN = NINT + 1;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s1;
   logic [NPIN-1:0] pin_s2;
   logic [NPIN-1:0] pin_s3;
   logic [NPIN-1:0] pin_q;

   assign pin_raw = {clock_mult_select, int_request};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_sync
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               pin_s1[gi] <= 1'b0;
               pin_s2[gi] <= 1'b0;
               pin_s3[gi] <= 1'b0;
               pin_q[gi] <= 1'b0;
            end
            else
            begin
               pin_s1[gi] <= pin_raw[gi];
               pin_s2[gi] <= pin_s1[gi];
               pin_s3[gi] <= pin_s2[gi];
               if (pin_s2[gi] == pin_s3[gi])
                  pin_q[gi] <= pin_s3[gi];
            end
         end
      end
   endgenerate

   logic [NINT-1:0] int_sync;
   logic bypass;
   assign int_sync = pin_q[NINT-1:0];
   assign bypass = (pin_q[NINT] == MULT_SEL_X1);

   // The synchronised strap reads low until the chain has filled, which would look like bypass.
   // The clock generator is held off until then, so an x4 part never reports lock early.
   logic [2:0] strap_wait;
   logic strap_ok;
   assign strap_ok = (strap_wait == STRAP_SETTLE_CYCLES);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         strap_wait <= 3'h0;
      else if (!strap_ok)
         strap_wait <= strap_wait + 3'h1;
   end

   // Registers.
   logic [5:0] power_down_field;
   logic global_int_enable;
   logic [31:0] int_enable_reg;
   pd_state_e state;
   logic [3:0] arm_cnt;
   logic light_any;
   logic last_wake_isr;
   logic pll_locked;

   // AXI4-Lite write path: address and data are taken in either order, then answered together.
   logic aw_held;
   logic w_held;
   logic [AXI_AW-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   logic [1:0] wr_idx;
   logic field_wr;
   logic [5:0] new_field;

   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   assign wr_fire = aw_held && w_held && !bvalid;
   assign wr_idx = reg_index(aw_addr_q);
   assign new_field = w_data_q[POWER_DOWN_FIELD_MSB:POWER_DOWN_FIELD_LSB];
   // The whole field sits in byte lane 1, so one strobed write in the run state updates all six bits.
   assign field_wr = wr_fire && (wr_idx == IDX_CTRL) && w_strb_q[1] && (state == ST_RUN);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (wr_fire)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         global_int_enable <= GIE_RST;
         int_enable_reg <= INT_ENABLE_RST;
      end
      else if (wr_fire)
      begin
         if (wr_idx == IDX_CTRL && w_strb_q[0])
            global_int_enable <= w_data_q[GIE_BIT];
         if (wr_idx == IDX_IE)
         begin
            for (int b = 0; b < 4; b++)
            begin
               if (w_strb_q[b])
                  int_enable_reg[8*b +: 8] <= w_data_q[8*b +: 8];
            end
         end
      end
   end

   // Wake decode during light sleep.
   logic [NINT-1:0] ie_mask;
   logic wake_enabled;
   logic wake_any;
   logic isr_allowed;
   assign ie_mask = int_enable_reg[IE_LSB +: NINT];
   assign wake_enabled = |(int_sync & ie_mask);
   assign wake_any = |int_sync;
   assign isr_allowed = wake_enabled && global_int_enable && int_enable_reg[NMI_ENABLE_BIT_BIT];

   // Mode sequencer. The field is held while asleep and cleared on wake so the core does not re-enter.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= ST_RUN;
         power_down_field <= POWER_DOWN_FIELD_RST;
         arm_cnt <= '0;
         light_any <= 1'b0;
         wake_isr <= 1'b0;
         wake_resume <= 1'b0;
         last_wake_isr <= 1'b0;
      end
      else
      begin
         wake_isr <= 1'b0;
         wake_resume <= 1'b0;
         case (state)
            ST_RUN:
            begin
               if (field_wr)
               begin
                  power_down_field <= new_field;
                  if (is_pd_code(new_field))
                  begin
                     state <= ST_ARMING;
                     arm_cnt <= ENTRY_CNT_INIT;
                  end
               end
            end
            ST_ARMING:
            begin
               if (arm_cnt != 4'h0)
                  arm_cnt <= arm_cnt - 4'h1;
               else
               begin
                  case (power_down_field)
                     PD_LIGHT_EN: state <= ST_LIGHT;
                     PD_LIGHT_ANY: state <= ST_LIGHT;
                     PD_CLK_STOP: state <= ST_CLK_STOP;
                     PD_PLL_STOP: state <= ST_PLL_STOP;
                     default: state <= ST_RUN;
                  endcase
                  light_any <= (power_down_field == PD_LIGHT_ANY);
               end
            end
            ST_LIGHT:
            begin
               if (wake_enabled || (light_any && wake_any))
               begin
                  state <= ST_RUN;
                  power_down_field <= PD_NONE;
                  wake_isr <= isr_allowed;
                  wake_resume <= !isr_allowed;
                  last_wake_isr <= isr_allowed;
               end
            end
            // Deep sleeps have no exit here; only the reset branch above leaves them.
            ST_CLK_STOP: state <= ST_CLK_STOP;
            ST_PLL_STOP: state <= ST_PLL_STOP;
            default: state <= ST_RUN;
         endcase
      end
   end

   logic deep;
   assign deep = (state == ST_CLK_STOP) || (state == ST_PLL_STOP);
   assign sleep_active = (state == ST_LIGHT);
   assign cpu_core_enable = ((state == ST_RUN) || (state == ST_ARMING)) && pll_locked;
   assign int_logic_enable = !deep && pll_locked;
   assign dma_enable = !deep && pll_locked;
   assign pll_out_enable = !deep;
   assign pll_in_enable = (state != ST_PLL_STOP);
   // Only synchronous outputs freeze; asynchronous or externally clocked peripherals may still move.
   assign io_freeze = deep;

   pll_tick_gen #(
      .REF_DIV(REF_DIV),
      .MULT(MULT_X4),
      .LOCK_CYCLES(LOCK_CYCLES)
   ) u_ticks (
      .aclk(aclk),
      .aresetn(aresetn),
      .bypass(bypass && strap_ok),
      .pll_in_enable(pll_in_enable && strap_ok),
      .pll_out_enable(pll_out_enable),
      .pll_locked(pll_locked),
      .cpu_clock_out(cpu_clock_out),
      .half_clock_out(half_clock_out)
   );

   // AXI4-Lite read path: one-cycle answer, unmapped offsets give SLVERR with zero data.
   logic [31:0] rd_word;
   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (reg_index(araddr))
         IDX_CTRL:
         begin
            rd_word[POWER_DOWN_FIELD_MSB:POWER_DOWN_FIELD_LSB] = power_down_field;
            rd_word[GIE_BIT] = global_int_enable;
         end
         IDX_IE: rd_word = int_enable_reg;
         IDX_STAT: rd_word = {24'h00_0000, !bypass, light_any, last_wake_isr, pll_locked, state, cpu_core_enable};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   assign arready = !rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= (reg_index(araddr) == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
   end

   logic arm_start;
   assign arm_start = field_wr && is_pd_code(new_field);

   property p_entry_delay;
      @(posedge aclk) disable iff (!aresetn)
      arm_start |=> (state == ST_ARMING) [*8] ##1 (state != ST_ARMING && state != ST_RUN);
   endproperty
   a_entry_delay: assert property (p_entry_delay) else $error("sleep not entered eight cycles after write");

   property p_reserved_code;
      @(posedge aclk) disable iff (!aresetn)
      (field_wr && !is_pd_code(new_field)) |=> (state == ST_RUN) ##1 (state == ST_RUN);
   endproperty
   a_reserved_code: assert property (p_reserved_code) else $error("reserved code left run state");

   property p_light_gating;
      @(posedge aclk) disable iff (!aresetn)
      (state == ST_LIGHT) |-> !cpu_core_enable && (int_logic_enable == pll_locked);
   endproperty
   a_light_gating: assert property (p_light_gating) else $error("light sleep clock gating wrong");

   property p_light_dma;
      @(posedge aclk) disable iff (!aresetn)
      (state == ST_LIGHT && pll_locked) |-> dma_enable;
   endproperty
   a_light_dma: assert property (p_light_dma) else $error("dma stopped in light sleep");

   property p_deep_hold;
      @(posedge aclk) disable iff (!aresetn)
      deep |=> $stable(state) && io_freeze;
   endproperty
   a_deep_hold: assert property (p_deep_hold) else $error("deep sleep left without reset");

   property p_clk_stop;
      @(posedge aclk) disable iff (!aresetn)
      (state == ST_CLK_STOP) |=> !pll_out_enable && pll_in_enable && !cpu_clock_out [*2];
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("clock stop sleep outputs wrong");

   property p_pll_stop;
      @(posedge aclk) disable iff (!aresetn)
      (state == ST_PLL_STOP) |=> !pll_in_enable && !cpu_clock_out ##1 (bypass || !pll_locked);
   endproperty
   a_pll_stop: assert property (p_pll_stop) else $error("pll stop sleep kept the pll running");

   property p_wake_isr;
      @(posedge aclk) disable iff (!aresetn)
      (state == ST_LIGHT && isr_allowed) |=> wake_isr && !wake_resume && (state == ST_RUN);
   endproperty
   a_wake_isr: assert property (p_wake_isr) else $error("enabled wake did not run service routine");

   property p_wake_resume;
      @(posedge aclk) disable iff (!aresetn)
      (state == ST_LIGHT && light_any && wake_any && !isr_allowed) |=> wake_resume && !wake_isr;
   endproperty
   a_wake_resume: assert property (p_wake_resume) else $error("plain wake did not resume");

   property p_enabled_only;
      @(posedge aclk) disable iff (!aresetn)
      (state == ST_LIGHT && !light_any && !wake_enabled) |=> (state == ST_LIGHT) && !wake_resume;
   endproperty
   a_enabled_only: assert property (p_enabled_only) else $error("non-enabled interrupt woke enabled-only sleep");

   property p_lock_gate;
      @(posedge aclk) disable iff (!aresetn)
      $rose(cpu_core_enable) |-> $past(pll_locked) || $rose(pll_locked) || (state == ST_RUN);
   endproperty
   a_lock_gate: assert property (p_lock_gate) else $error("core ran before pll lock");

   property p_x4_rate;
      @(posedge aclk) disable iff (!aresetn)
      (cpu_clock_out && !bypass) |=> !cpu_clock_out [*3];
   endproperty
   a_x4_rate: assert property (p_x4_rate) else $error("times-four cpu tick too fast");

   c_light: cover property (@(posedge aclk) disable iff (!aresetn) arm_start ##9 (state == ST_LIGHT));
   c_wake_isr: cover property (@(posedge aclk) disable iff (!aresetn) wake_isr);
   c_clk_stop: cover property (@(posedge aclk) disable iff (!aresetn) state == ST_CLK_STOP);
   c_pll_stop: cover property (@(posedge aclk) disable iff (!aresetn) state == ST_PLL_STOP);

endmodule : power_down_mode_control

// File: rtl/pdm_pkg.sv
// Constants, register map and state type shared by the power-down controller.
// Assumes a single 250 MHz clock and an AXI4-Lite master with 32-bit data.
package pdm_pkg;

   localparam int AXI_AW = 8;

   // Register byte offsets.
   localparam logic [AXI_AW-1:0] CTRL_STATUS_OFS = 8'h00;
   localparam logic [AXI_AW-1:0] INT_ENABLE_OFS = 8'h04;
   localparam logic [AXI_AW-1:0] PD_STATUS_OFS = 8'h08;

   // Register index codes produced by the address decoder.
   localparam logic [1:0] IDX_CTRL = 2'h0;
   localparam logic [1:0] IDX_IE = 2'h1;
   localparam logic [1:0] IDX_STAT = 2'h2;
   localparam logic [1:0] IDX_NONE = 2'h3;

   // Field positions.
   localparam int POWER_DOWN_FIELD_LSB = 10;
   localparam int POWER_DOWN_FIELD_MSB = 15;
   localparam int GIE_BIT = 0;
   localparam int NMI_ENABLE_BIT_BIT = 1;
   localparam int IE_LSB = 4;

   // Reset values.
   localparam logic [5:0] POWER_DOWN_FIELD_RST = 6'h00;
   localparam logic GIE_RST = 1'b0;
   localparam logic [31:0] INT_ENABLE_RST = 32'h0000_0000;

   // Power-down field codes.
   localparam logic [5:0] PD_NONE = 6'h00;
   localparam logic [5:0] PD_LIGHT_EN = 6'h09;
   localparam logic [5:0] PD_LIGHT_ANY = 6'h11;
   localparam logic [5:0] PD_CLK_STOP = 6'h1A;
   localparam logic [5:0] PD_PLL_STOP = 6'h1C;

   // Light sleep takes effect this many cycles after the field write.
   localparam int ENTRY_CYCLES = 8;

   // Cycles after reset until the pin synchronisers hold the real strap level.
   localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;
   localparam logic [3:0] ENTRY_CNT_INIT = 4'(ENTRY_CYCLES - 1);

   // Lock wait: typical lock time plus the allowed margin, rounded up.
   localparam int CLK_PERIOD_PS = 4000;
   localparam int LOCK_TYP_NS = 75000;
   localparam int LOCK_MARGIN_PCT = 150;
   localparam int LOCK_MAX_NS = LOCK_TYP_NS * (100 + LOCK_MARGIN_PCT) / 100;
   localparam int LOCK_CYCLES_DEF = (LOCK_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Reference clock modelled as one enable pulse every REF_DIV_DEF cycles.
   localparam int REF_DIV_DEF = 16;
   localparam int MULT_X4 = 4;
   localparam logic MULT_SEL_X1 = 1'b0;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {ST_RUN, ST_ARMING, ST_LIGHT, ST_CLK_STOP, ST_PLL_STOP} pd_state_e;

endpackage : pdm_pkg

// File: rtl/pll_tick_gen.sv
// Reference divider, clock multiplier and lock timer as clock-enable pulses.
// Assumes REF_DIV and REF_DIV/MULT are powers of two and REF_DIV > MULT.
`timescale 1ns/1ps
module pll_tick_gen
#(
   parameter int REF_DIV = pdm_pkg::REF_DIV_DEF,
   parameter int MULT = pdm_pkg::MULT_X4,
   parameter int LOCK_CYCLES = pdm_pkg::LOCK_CYCLES_DEF
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bypass,
   input wire logic pll_in_enable,
   input wire logic pll_out_enable,
   output logic pll_locked,
   output logic cpu_clock_out,
   output logic half_clock_out
);
   import pdm_pkg::*;

   localparam int RW = $clog2(REF_DIV);
   localparam int PW = $clog2(REF_DIV / MULT);
   localparam int LW = $clog2(LOCK_CYCLES + 1);

   logic [RW-1:0] ref_cnt;
   logic [LW-1:0] lock_cnt;
   logic half_phase;
   logic ref_wrap;
   logic pll_wrap;
   logic tick_now;

   assign ref_wrap = (ref_cnt == RW'(REF_DIV - 1));
   assign pll_wrap = (ref_cnt[PW-1:0] == {PW{1'b1}});
   // In bypass the reference itself is the CPU clock; otherwise the PLL output runs MULT times faster.
   assign tick_now = pll_in_enable && pll_out_enable && pll_locked && (bypass ? ref_wrap : pll_wrap);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ref_cnt <= '0;
      else
         ref_cnt <= ref_wrap ? '0 : ref_cnt + RW'(1);
   end

   // The timer restarts whenever the PLL loses its input, so waking through reset relocks in full.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !pll_in_enable || bypass)
         lock_cnt <= '0;
      else if (lock_cnt != LW'(LOCK_CYCLES))
         lock_cnt <= lock_cnt + LW'(1);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pll_locked <= 1'b0;
      else
         pll_locked <= bypass || (lock_cnt == LW'(LOCK_CYCLES));
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cpu_clock_out <= 1'b0;
         half_clock_out <= 1'b0;
         half_phase <= 1'b0;
      end
      else
      begin
         cpu_clock_out <= tick_now;
         half_clock_out <= tick_now && half_phase;
         if (tick_now)
            half_phase <= !half_phase;
      end
   end

endmodule : pll_tick_gen

// File: verif/int_source_model.sv
// Interrupt source model: raises request lines on command and holds them as levels.
// Assumes a wake pulse from the controller stands for the acknowledge of the request.
`timescale 1ns/1ps
module int_source_model
#(
   parameter int NINT = 12
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [NINT-1:0] raise,
   input wire logic ack,
   output logic [NINT-1:0] int_request
);
   // Lines stay high until acknowledged, so a slow synchroniser still sees them.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || ack)
         int_request <= '0;
      else
         int_request <= int_request | raise;
   end
endmodule : int_source_model

// File: verif/tb_top.sv
// Bench for the power-down controller: register tasks, sleep entry, wake and clock checks.
// Assumes the interrupt source model on the request lines and a shortened lock count.
`timescale 1ns/1ps
module tb_top;
   import pdm_pkg::*;
   localparam int LOCK = 20;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic mult = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [11:0] raise = 12'h000;
   logic awready, wready, bvalid, arready, rvalid, ta, tb;
   logic core_en, int_en, dma_en, pll_out, pll_in, freeze, sleep, w_isr, w_res, cpu_clk, half_clk;
   logic [31:0] rdata, rd;
   logic [1:0] bresp, rresp, rsp, how;
   logic [11:0] int_request;
   logic [31:0] lc [4] = '{32'h2401, 32'h4400, 32'h4400, 32'h4401};
   logic [31:0] le [4] = '{32'h12, 32'h12, 32'h12, 32'h10};
   logic [11:0] ll [4] = '{12'h001, 12'h004, 12'h001, 12'h001};
   logic [1:0] lh [4] = '{2'b10, 2'b01, 2'b01, 2'b01};
   int mismatches = 0;
   int num_checks = 0;
   int n, m;

   power_down_mode_control #(.NINT(12), .REF_DIV(16), .LOCK_CYCLES(LOCK)) power_down_mode_control_i (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .int_request(int_request),
      .clock_mult_select(mult), .cpu_core_enable(core_en), .int_logic_enable(int_en),
      .dma_enable(dma_en), .pll_out_enable(pll_out), .pll_in_enable(pll_in), .io_freeze(freeze),
      .sleep_active(sleep), .wake_isr(w_isr), .wake_resume(w_res), .cpu_clock_out(cpu_clk),
      .half_clock_out(half_clk));

   int_source_model #(.NINT(12)) int_source_model_i (.aclk(aclk), .aresetn(aresetn), .raise(raise),
      .ack(w_isr | w_res), .int_request(int_request));

   initial
   begin
      forever #2 aclk = ~aclk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   // Handshakes are sampled at the falling edge, which holds what the next rising edge sees.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic tw;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      for (int i = 0; i < 100 && !tb; i++)
      begin
         @(negedge aclk);
         ta = awready;
         tw = wready;
         tb = bvalid;
         rsp = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
      cmp({31'h0, tb}, 32'h1);
   endtask : wr

   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tb = 1'b0;
      for (int i = 0; i < 100 && !tb; i++)
      begin
         @(negedge aclk);
         ta = arready;
         tb = rvalid;
         rd = rdata;
         rsp = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tb) rready <= 1'b0;
      end
      cmp({31'h0, tb}, 32'h1);
   endtask : rd_reg

   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
      @(negedge aclk);
   endtask : tick

   task automatic wake(input logic [11:0] lines);
      @(posedge aclk);
      raise <= lines;
      @(posedge aclk);
      raise <= 12'h000;
      how = 2'b00;
      for (int i = 0; i < 40 && how == 2'b00; i++)
      begin
         @(negedge aclk);
         how = {w_isr, w_res};
      end
   endtask : wake

   task automatic reset_lock(input int lo);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      n = 0;
      @(negedge aclk);
      while (core_en !== 1'b1 && n < 200)
      begin
         @(negedge aclk);
         n++;
      end
      cmp(32'(n >= lo && n < 200), 32'h1);
   endtask : reset_lock

   task automatic clocks(input int e1, input int e2);
      n = 0;
      m = 0;
      repeat (64)
      begin
         @(negedge aclk);
         n += int'(cpu_clk === 1'b1);
         m += int'(half_clk === 1'b1);
      end
      cmp(n, e1);
      cmp(m, e2);
   endtask : clocks

   initial
   begin
      repeat (5000) @(posedge aclk);
      mismatches++;
      complete_run();
   end

   initial
   begin
      reset_lock(LOCK);
      rd_reg(CTRL_STATUS_OFS);
      cmp(rd, 32'h0);
      rd_reg(8'h0C);
      cmp(rd, 32'h0);
      cmp({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(8'h0C, 32'h0000_2400);
      cmp({30'h0, rsp}, {30'h0, RESP_SLVERR});
      clocks(16, 8);
      wr(CTRL_STATUS_OFS, 32'h3C00);
      cmp({30'h0, rsp}, {30'h0, RESP_OKAY});
      tick(10);
      cmp({sleep, core_en}, 2'b01);
      for (int i = 0; i < 4; i++)
      begin
         wr(INT_ENABLE_OFS, le[i]);
         wr(CTRL_STATUS_OFS, lc[i]);
         tick(6);
         cmp(sleep, 1'b0);
         tick(1);
         cmp({sleep, core_en, int_en, dma_en}, 4'b1011);
         if (i == 0)
         begin
            wake(12'h004);
            cmp(how, 2'b00);
         end
         wake(ll[i]);
         cmp(how, lh[i]);
         tick(1);
         cmp({sleep, core_en}, 2'b01);
      end
      for (int i = 0; i < 2; i++)
      begin
         wr(CTRL_STATUS_OFS, (i == 0) ? 32'h6801 : 32'h7001);
         tick(7);
         cmp({pll_out, pll_in, freeze, int_en, core_en}, {1'b0, i == 0, 3'b100});
         wake(12'h001);
         cmp(how, 2'b00);
         reset_lock(LOCK);
         rd_reg(CTRL_STATUS_OFS);
         cmp({29'h0, pll_out, pll_in, freeze}, 32'h0000_0006);
         cmp(rd, 32'h0);
      end
      mult <= 1'b0;
      reset_lock(1);
      clocks(4, 2);
      complete_run();
   end
endmodule : tb_top
